// ==== hdl/odac_cfg.svh ====
`ifndef ODAC_CFG_SVH
`define ODAC_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ODAC_CLK_NS 25
`define ODAC_POR_NS 1000
`define ODAC_POR_CYC ((`ODAC_POR_NS + `ODAC_CLK_NS - 1) / `ODAC_CLK_NS)
`define ODAC_FRAME_BITS 32
`define ODAC_LAST_BIT 5'd31

// ----------------------------------------------------------------
// Frame fields
// ----------------------------------------------------------------
`define ODAC_CMD_HI 27
`define ODAC_CMD_LO 24
`define ODAC_ADR_HI 23
`define ODAC_ADR_LO 20
`define ODAC_DAT_HI 19
`define ODAC_DAT_LO 4
`define ODAC_PD_HI 9
`define ODAC_PD_LO 8
`define ODAC_ADDR_ALL 4'hF
`define ODAC_MASK_ALL 8'hFF
`define ODAC_MID_CODE 16'h8000
`define ODAC_FULL_CODE 16'hFFFF

// ----------------------------------------------------------------
// Bus map
// ----------------------------------------------------------------
`define ODAC_REG_CTRL 8'h00
`define ODAC_REG_STATUS 8'h04
`define ODAC_REG_PD 8'h08
`define ODAC_BANK_DAC 3'h1
`define ODAC_BANK_IN 3'h2
`define ODAC_CTRL_RST 3'h0
`define ODAC_RESP_OK 2'h0
`define ODAC_RESP_ERR 2'h2

`endif

// ==== hdl/odac_pkg.sv ====
package odac_pkg;

   typedef enum logic [3:0] {
      CMD_WR_IN = 4'h0,
      CMD_UPD = 4'h1,
      CMD_WR_UPD_ALL = 4'h2,
      CMD_WR_UPD = 4'h3,
      CMD_PWR = 4'h4,
      CMD_CLR_CODE = 4'h5,
      CMD_LD_MASK = 4'h6,
      CMD_RESET = 4'h7,
      CMD_REF = 4'h8
   } odac_cmd_e;

   typedef enum logic [1:0] {
      PD_NORMAL = 2'h0,
      PD_1K = 2'h1,
      PD_100K = 2'h2,
      PD_TRI = 2'h3
   } odac_pd_e;

   typedef enum logic [1:0] {
      RES_16 = 2'h0,
      RES_14 = 2'h1,
      RES_12 = 2'h2
   } odac_res_e;

   typedef enum logic [1:0] {
      FR_IDLE = 2'h0,
      FR_SHIFT = 2'h1,
      FR_WAIT = 2'h3
   } odac_frame_e;

   typedef logic [15:0] odac_code_t;
   typedef odac_code_t [7:0] odac_bank_t;
   typedef logic [7:0][1:0] odac_pdbank_t;

   typedef struct packed {
      logic frame_sel_n;
      logic sclk;
      logic sdin;
      logic load_outputs_n;
      logic clear_outputs_n;
   } odac_pins_s;

endpackage

// ==== hdl/odac_sync.sv ====
`timescale 1ns/1ps
module odac_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic [WIDTH-1:0] i_d,
   output logic [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_reg <= RST_VAL;
         o_q <= RST_VAL;
      end else begin
         meta_reg <= i_d;
         o_q <= meta_reg;
      end
   end
endmodule // odac_sync

// ==== hdl/odac_core.sv ====
`timescale 1ns/1ps
`include "odac_cfg.svh"
module odac_core (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_frame_sel_n,
   input wire logic i_sclk,
   input wire logic i_sdin,
   input wire logic i_load_outputs_n,
   input wire logic i_clear_outputs_n,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [7:0] i_awaddr,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [7:0] i_araddr,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output odac_pkg::odac_bank_t o_dac_code,
   output odac_pkg::odac_pdbank_t o_pd_mode,
   output logic o_ref_en
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   odac_pkg::odac_pins_s pins_raw;
   odac_pkg::odac_pins_s pins_q;
   odac_pkg::odac_pins_s pins_d_reg;

   assign pins_raw = '{frame_sel_n: i_frame_sel_n, sclk: i_sclk, sdin: i_sdin,
      load_outputs_n: i_load_outputs_n, clear_outputs_n: i_clear_outputs_n};

   odac_sync #(.WIDTH(5), .RST_VAL(5'h1B)) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_d(pins_raw),
      .o_q(pins_q)
   );

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pins_d_reg <= 5'h1B;
      end else begin
         pins_d_reg <= pins_q;
      end
   end

   // ----------------------------------------------------------------
   // Power-on interval
   // ----------------------------------------------------------------
   logic [7:0] por_cnt_reg;
   logic por_busy;
   logic exec_reg;
   logic [31:0] word_reg;
   odac_pkg::odac_cmd_e cmd;
   logic [3:0] addr;

   assign por_busy = (por_cnt_reg != 8'h00);
   assign cmd = odac_pkg::odac_cmd_e'(word_reg[`ODAC_CMD_HI:`ODAC_CMD_LO]);
   assign addr = word_reg[`ODAC_ADR_HI:`ODAC_ADR_LO];

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         por_cnt_reg <= 8'(`ODAC_POR_CYC);
      end else if (exec_reg && cmd == odac_pkg::CMD_RESET) begin
         por_cnt_reg <= 8'(`ODAC_POR_CYC);
      end else if (por_busy) begin
         por_cnt_reg <= por_cnt_reg - 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   logic sclk_fall;
   logic fs_fall;
   logic ld_fall;
   logic clr_fall;

   assign sclk_fall = pins_d_reg.sclk && !pins_q.sclk;
   assign fs_fall = pins_d_reg.frame_sel_n && !pins_q.frame_sel_n;
   // Load and clear pin edges during the power-on interval are dropped, not deferred
   assign ld_fall = pins_d_reg.load_outputs_n && !pins_q.load_outputs_n && !por_busy;
   assign clr_fall = pins_d_reg.clear_outputs_n && !pins_q.clear_outputs_n && !por_busy;

   // ----------------------------------------------------------------
   // Frame receiver
   // ----------------------------------------------------------------
   odac_pkg::odac_frame_e state_reg;
   logic [31:0] shift_reg;
   logic [4:0] bit_cnt_reg;

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg <= odac_pkg::FR_IDLE;
         shift_reg <= 32'h0000_0000;
         bit_cnt_reg <= 5'h00;
         exec_reg <= 1'b0;
         word_reg <= 32'h0000_0000;
      end else begin
         exec_reg <= 1'b0;
         if (clr_fall) begin
            // Clear pin aborts a write in progress
            state_reg <= odac_pkg::FR_IDLE;
            shift_reg <= 32'h0000_0000;
            bit_cnt_reg <= 5'h00;
         end else if (fs_fall) begin
            state_reg <= odac_pkg::FR_SHIFT;
            shift_reg <= 32'h0000_0000;
            bit_cnt_reg <= 5'h00;
         end else begin
            case (state_reg)
               odac_pkg::FR_SHIFT: begin
                  if (pins_q.frame_sel_n) begin
                     state_reg <= odac_pkg::FR_IDLE;
                     shift_reg <= 32'h0000_0000;
                     bit_cnt_reg <= 5'h00;
                  end else if (sclk_fall) begin
                     shift_reg <= {shift_reg[30:0], pins_q.sdin};
                     bit_cnt_reg <= bit_cnt_reg + 5'h01;
                     if (bit_cnt_reg == `ODAC_LAST_BIT) begin
                        exec_reg <= 1'b1;
                        word_reg <= {shift_reg[30:0], pins_q.sdin};
                        state_reg <= odac_pkg::FR_WAIT;
                     end
                  end
               end
               odac_pkg::FR_WAIT: begin
                  // Further clocks ignored until a new frame-select fall
                  if (pins_q.frame_sel_n) begin
                     state_reg <= odac_pkg::FR_IDLE;
                  end
               end
               default: begin
                  state_reg <= odac_pkg::FR_IDLE;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Control register and code alignment
   // ----------------------------------------------------------------
   logic [2:0] ctrl_reg;
   odac_pkg::odac_res_e res;
   odac_pkg::odac_code_t code;
   odac_pkg::odac_code_t por_code;
   odac_pkg::odac_code_t clr_code;
   logic [1:0] clr_sel_reg;
   logic [7:0] ld_mask_reg;
   logic clr_active_reg;

   assign res = odac_pkg::odac_res_e'(ctrl_reg[1:0]);

   function automatic odac_pkg::odac_code_t align(input logic [15:0] w,
                                                  input odac_pkg::odac_res_e r);
      case (r)
         odac_pkg::RES_14: align = {2'b00, w[15:2]};
         odac_pkg::RES_12: align = {4'h0, w[15:4]};
         default: align = w;
      endcase
   endfunction

   assign code = align(word_reg[`ODAC_DAT_HI:`ODAC_DAT_LO], res);
   assign por_code = ctrl_reg[2] ? align(`ODAC_MID_CODE, res) : 16'h0000;
   assign clr_code = (clr_sel_reg == 2'h1) ? align(`ODAC_MID_CODE, res) :
                     (clr_sel_reg == 2'h2) ? align(`ODAC_FULL_CODE, res) : 16'h0000;

   // ----------------------------------------------------------------
   // Input and DAC registers
   // ----------------------------------------------------------------
   odac_pkg::odac_bank_t in_reg;
   logic addr_ok;
   logic [7:0] ch_sel;

   assign addr_ok = (addr[3] == 1'b0) || (addr == `ODAC_ADDR_ALL);
   assign ch_sel = !addr_ok ? 8'h00 :
                   (addr == `ODAC_ADDR_ALL) ? `ODAC_MASK_ALL : 8'h01 << addr[2:0];

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         in_reg <= '0;
         o_dac_code <= '0;
      end else if (por_busy) begin
         // Power-on code applied after release, once control is known
         for (int ch = 0; ch < 8; ch++) begin
            in_reg[ch] <= por_code;
            o_dac_code[ch] <= por_code;
         end
      end else if (clr_fall) begin
         if (clr_sel_reg != 2'h3) begin
            for (int ch = 0; ch < 8; ch++) begin
               in_reg[ch] <= clr_code;
               o_dac_code[ch] <= clr_code;
            end
         end
      end else begin
         for (int ch = 0; ch < 8; ch++) begin
            if (ld_fall) begin
               o_dac_code[ch] <= in_reg[ch];
            end
            if (exec_reg) begin
               case (cmd)
                  odac_pkg::CMD_WR_IN: begin
                     if (ch_sel[ch]) begin
                        in_reg[ch] <= code;
                        if (!pins_q.load_outputs_n || ld_mask_reg[ch]) begin
                           o_dac_code[ch] <= code;
                        end
                     end
                  end
                  odac_pkg::CMD_UPD: begin
                     if (ch_sel[ch]) begin
                        o_dac_code[ch] <= in_reg[ch];
                     end
                  end
                  odac_pkg::CMD_WR_UPD_ALL: begin
                     if (ch_sel[ch]) begin
                        in_reg[ch] <= code;
                        o_dac_code[ch] <= code;
                     end else if (addr_ok) begin
                        o_dac_code[ch] <= in_reg[ch];
                     end
                  end
                  odac_pkg::CMD_WR_UPD: begin
                     if (ch_sel[ch]) begin
                        in_reg[ch] <= code;
                        o_dac_code[ch] <= code;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Power-down state
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_pd_mode <= '0;
      end else if (por_busy) begin
         o_pd_mode <= '0;
      end else if (exec_reg && cmd == odac_pkg::CMD_PWR) begin
         // With the reference on, only an all-channel mask is honoured
         if (!o_ref_en || word_reg[7:0] == `ODAC_MASK_ALL) begin
            for (int ch = 0; ch < 8; ch++) begin
               if (word_reg[ch]) begin
                  o_pd_mode[ch] <= word_reg[`ODAC_PD_HI:`ODAC_PD_LO];
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Clear code, load mask, reference
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         clr_sel_reg <= 2'h0;
         ld_mask_reg <= 8'h00;
         o_ref_en <= 1'b0;
      end else if (por_busy) begin
         clr_sel_reg <= 2'h0;
         ld_mask_reg <= 8'h00;
         o_ref_en <= 1'b0;
      end else if (exec_reg) begin
         case (cmd)
            odac_pkg::CMD_CLR_CODE: clr_sel_reg <= word_reg[1:0];
            odac_pkg::CMD_LD_MASK: ld_mask_reg <= word_reg[7:0];
            odac_pkg::CMD_REF: o_ref_en <= word_reg[0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         clr_active_reg <= 1'b0;
      end else if (por_busy || (exec_reg && !clr_fall)) begin
         clr_active_reg <= 1'b0;
      end else if (clr_fall) begin
         clr_active_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   logic aw_full_reg;
   logic w_full_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic w_be0_reg;

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         o_bvalid <= 1'b0;
         o_bresp <= `ODAC_RESP_OK;
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_be0_reg <= 1'b0;
         ctrl_reg <= `ODAC_CTRL_RST;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_addr_reg <= i_awaddr;
            aw_full_reg <= 1'b1;
            o_awready <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            w_data_reg <= i_wdata;
            w_be0_reg <= i_wstrb[0];
            w_full_reg <= 1'b1;
            o_wready <= 1'b0;
         end
         if (aw_full_reg && w_full_reg && !o_bvalid) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            o_bvalid <= 1'b1;
            if (aw_addr_reg[7:2] == 6'(`ODAC_REG_CTRL >> 2)) begin
               o_bresp <= `ODAC_RESP_OK;
               if (w_be0_reg) begin
                  ctrl_reg <= w_data_reg[2:0];
               end
            end else begin
               o_bresp <= `ODAC_RESP_ERR;
            end
         end
         if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
      end
   end

   logic [31:0] rd_mux;
   logic rd_hit;

   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      if (i_araddr[7:5] == `ODAC_BANK_DAC) begin
         rd_mux = {16'h0000, o_dac_code[i_araddr[4:2]]};
      end else if (i_araddr[7:5] == `ODAC_BANK_IN) begin
         rd_mux = {16'h0000, in_reg[i_araddr[4:2]]};
      end else if (i_araddr[7:2] == 6'(`ODAC_REG_CTRL >> 2)) begin
         rd_mux = {29'h0, ctrl_reg};
      end else if (i_araddr[7:2] == 6'(`ODAC_REG_STATUS >> 2)) begin
         rd_mux = {16'h0000, 1'b0, state_reg != odac_pkg::FR_IDLE, por_busy,
                   clr_active_reg, clr_sel_reg, 1'b0, o_ref_en, ld_mask_reg};
      end else if (i_araddr[7:2] == 6'(`ODAC_REG_PD >> 2)) begin
         rd_mux = {16'h0000, o_pd_mode};
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= `ODAC_RESP_OK;
      end else if (i_arvalid && o_arready) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b1;
         o_rdata <= rd_mux;
         o_rresp <= rd_hit ? `ODAC_RESP_OK : `ODAC_RESP_ERR;
      end else if (o_rvalid && i_rready) begin
         o_rvalid <= 1'b0;
         o_arready <= 1'b1;
      end
   end

endmodule // odac_core

// ==== tb/odac_core_asserts.sv ====
`timescale 1ns/1ps
module odac_core_asserts (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_frame_sel_n,
   input wire logic i_sclk,
   input wire logic i_sdin,
   input wire logic i_load_outputs_n,
   input wire logic i_clear_outputs_n,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic [7:0] i_awaddr,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic [1:0] o_bresp,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [7:0] i_araddr,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0] o_rresp,
   input wire odac_pkg::odac_bank_t o_dac_code,
   input wire odac_pkg::odac_pdbank_t o_pd_mode,
   input wire logic o_ref_en
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   // ----------------------------------------------------------------
   // Quiet time: frame select, load and clear pins high, no bus write address
   // ----------------------------------------------------------------
   logic [3:0] quiet_cnt;
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         quiet_cnt <= 4'h0;
      end else if (!(i_frame_sel_n && i_load_outputs_n && i_clear_outputs_n) || i_awvalid) begin
         quiet_cnt <= 4'h0;
      end else if (quiet_cnt != 4'hF) begin
         quiet_cnt <= quiet_cnt + 4'h1;
      end
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   aw_taken_a: assert property (i_awvalid && o_awready |=> !o_awready)
      else $error("awready high after address taken");
   w_taken_a: assert property (i_wvalid && o_wready |=> !o_wready)
      else $error("wready high after data taken");
   b_answer_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:3] o_bvalid)
      else $error("no write response");
   b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped");
   b_done_a: assert property (o_bvalid && i_bready |=> !o_bvalid && o_awready && o_wready)
      else $error("write channel not released");
   r_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
      else $error("no read answer");
   r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata) && $stable(o_rresp))
      else $error("read answer dropped");
   por_state_a: assert property ($rose(i_rst_b) |-> !o_ref_en && o_dac_code == '0 && o_pd_mode == '0)
      else $error("wrong state after reset");
   idle_hold_a: assert property (quiet_cnt > 4'h7 |-> $stable(o_dac_code) && $stable(o_pd_mode) && $stable(o_ref_en))
      else $error("outputs moved while link idle");
   ref_pd_all_a: assert property (o_ref_en && $past(o_ref_en) && $changed(o_pd_mode) |-> o_pd_mode == {8{o_pd_mode[0]}})
      else $error("single channel power-down with reference on");
   wr_err_c: cover property (o_bvalid && i_bready && o_bresp == 2'h2);
   rd_c: cover property (o_rvalid && i_rready);
   pd_c: cover property ($changed(o_pd_mode));
   ref_c: cover property ($rose(o_ref_en));
endmodule // odac_core_asserts

bind odac_core odac_core_asserts u_odac_chk (.*);

// ==== tb/odac_host.sv ====
`timescale 1ns/1ps
module odac_host (
   input wire logic i_sys_clk,
   output odac_pkg::odac_pins_s o_pins
);
   initial o_pins = 5'b11011;
   // ----------------------------------------------------------------
   // Frame sender, frame pin edges fixed 11 ns after a system clock edge; load and clear pins change on the edge
   // ----------------------------------------------------------------
   // Serial clock stands high outside frames
   task automatic send(input logic [31:0] f, input int nb, input bit il);
      @(posedge i_sys_clk);
      #11 o_pins.frame_sel_n <= 1'b1;
      #100 o_pins.frame_sel_n <= 1'b0;
      for (int i = 31; i > 31 - nb; i--) begin
         o_pins.sdin <= f[i];
         #100 o_pins.sclk <= 1'b0;
         #100 o_pins.sclk <= 1'b1;
      end
      o_pins.sdin <= ~o_pins.sdin;
      // Short count raises select early: frame dropped
      #300 o_pins.frame_sel_n <= (il && nb == 32) ? 1'b0 : 1'b1;
   endtask
   task automatic set_pins(input logic ld, input logic cl);
      @(posedge i_sys_clk);
      o_pins.load_outputs_n <= ld;
      o_pins.clear_outputs_n <= cl;
   endtask
endmodule // odac_host

// ==== tb/tb_odac_core.sv ====
`timescale 1ns/1ps
module tb_odac_core;
   logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, ref_en;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   odac_pkg::odac_bank_t dac_code;
   odac_pkg::odac_pdbank_t pd_mode;
   odac_pkg::odac_pins_s pins;
   int errors, compares, cyc, seed, ref_m, mask_m, clr_m, res, ld_m, por_m;
   int in_m[8], dac_m[8], pd_m[8];

   odac_host u_host (.i_sys_clk(clk), .o_pins(pins));
   odac_core DUT (
      .i_sys_clk(clk), .i_rst_b(rst_b), .i_frame_sel_n(pins.frame_sel_n),
      .i_sclk(pins.sclk), .i_sdin(pins.sdin), .i_load_outputs_n(pins.load_outputs_n),
      .i_clear_outputs_n(pins.clear_outputs_n), .i_awvalid(awvalid), .o_awready(awready),
      .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
      .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
      .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
      .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .o_dac_code(dac_code),
      .o_pd_mode(pd_mode), .o_ref_en(ref_en));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Hang guard, well above the expected run
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         errors = errors + 1;
         complete_run();
      end
   end
   // ----------------------------------------------------------------
   // Reporting
   // ----------------------------------------------------------------
   task automatic complete_run();
      $display("Errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("Error t=%0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   task automatic chk_out();
      for (int i = 0; i < 8; i++) begin
         cmp(dac_code[i], dac_m[i], "dac code");
         cmp(pd_mode[i], pd_m[i], "power mode");
      end
      cmp(ref_en, ref_m, "reference");
   endtask
   // ----------------------------------------------------------------
   // Bus master
   // ----------------------------------------------------------------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            cmp(bresp, er, "write resp");
            bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                         input logic [31:0] m);
      @(posedge clk);
      arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            cmp(rdata & m, ed, "read data");
            cmp(rresp, er, "read resp");
            rready <= 1'b0;
            break;
         end
      end
   endtask
   // ----------------------------------------------------------------
   // Model
   // ----------------------------------------------------------------
   task automatic reset_model();
      for (int i = 0; i < 8; i++) begin
         in_m[i] = por_m; dac_m[i] = por_m; pd_m[i] = 0;
      end
      ref_m = 0; mask_m = 0; clr_m = 0;
   endtask
   task automatic exec(input logic [31:0] f);
      int c, a, v;
      c = f[27:24]; a = f[23:20]; v = f[19:4] >> (2 * res);
      for (int i = 0; i < 8; i++) if (a == i || a == 15) begin
         if (c == 0 || c == 2 || c == 3) in_m[i] = v;
         if (c == 3 || c == 0 && (ld_m == 0 || mask_m[i])) dac_m[i] = v;
         if (c == 1) dac_m[i] = in_m[i];
      end
      if (c == 2 && (a < 8 || a == 15)) dac_m = in_m;
      if (c == 4 && (ref_m == 0 || f[7:0] == 8'hFF))
         for (int i = 0; i < 8; i++) if (f[i]) pd_m[i] = f[9:8];
      if (c == 5) clr_m = f[1:0];
      if (c == 6) mask_m = f[7:0];
      if (c == 7) reset_model();
      if (c == 8) ref_m = f[0];
   endtask
   task automatic frame(input logic [31:0] f, input int nb, input bit il);
      u_host.send(f, nb, il);
      if (nb == 32) exec(f);
      chk_out();
      axi_rd(8'h20 + {3'h0, f[22:20], 2'h0}, dac_m[f[22:20]], 2'h0, 32'hFFFF);
      axi_rd(8'h40 + {3'h0, f[22:20], 2'h0}, in_m[f[22:20]], 2'h0, 32'hFFFF);
      axi_rd(8'h04, mask_m | ref_m << 8 | clr_m << 10, 2'h0, 32'hFFF);
   endtask
   task automatic pulse(input bit clr);
      int v;
      u_host.set_pins(clr & ld_m[0], !clr);
      repeat (4) @(posedge clk);
      u_host.set_pins(ld_m[0], 1'b1);
      repeat (8) @(posedge clk);
      v = clr_m == 0 ? 0 : clr_m == 1 ? 32'h8000 : 32'hFFFF;
      for (int i = 0; i < 8; i++) begin
         if (clr && clr_m != 3) begin
            in_m[i] = v >> (2 * res); dac_m[i] = in_m[i];
         end
         if (!clr) dac_m[i] = in_m[i];
      end
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [3:0] c;
      logic [31:0] f;
      seed = 32'h2869;
      rst_b = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
      rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF;
      reset_model();
      ld_m = 1; res = 0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (50) @(posedge clk);
      chk_out();
      axi_wr(8'h08, 32'h0, 2'h2);
      axi_rd(8'h10, 32'h0, 2'h2, 32'hFFFFFFFF);
      axi_rd(8'h00, 32'h0, 2'h0, 32'h7);
      for (int p = 0; p < 4; p++) begin
         res = p % 3;
         axi_wr(8'h00, res + 4 * (p == 0), 2'h0);
         por_m = 32'h8000 * (p == 0);
         ld_m = p != 1;
         u_host.set_pins(ld_m[0], 1'b1);
         repeat (8) @(posedge clk);
         if (ld_m == 0) dac_m = in_m;
         chk_out();
         for (int j = 0; j < 16; j++) begin
            c = (j + 5) % 16;
            if (c == 7 && p > 0) c = 4'h9;
            f = $random(seed);
            f[27:24] = c;
            if (c == 8) f[0] = p[0];
            if (c == 4 && p == 1) f[9:0] = 10'h3FF;
            frame(f, 32, p == 1);
            if (c == 7) repeat (50) @(posedge clk);
         end
         frame($random(seed), 1 + {$random(seed)} % 31, 1'b0);
         frame(32'h0500_0000 | p, 32, 1'b0);
         pulse(1'b1);
         chk_out();
         pulse(1'b0);
         chk_out();
      end
      complete_run();
   end
endmodule // tb_odac_core
